// File: verilog/swcfg_map.svh
// register offsets, field positions, reset values and timing counts of the switch config bank
// Operation
// RULE1: per-channel input termination bit 0 disconnects, 1 connects that channel's termination.
// RULE2: termination bits 0-3 drive source B channels 0-3, bits 4-7 source A 0-3.
// RULE3: termination bits 8-11 drive C3..C0, bits 12-15 drive D3..D0.
// RULE4: per-channel equalization bit 0 selects low level, 1 selects high level.
// RULE5: equalization bits map to channels exactly like the termination bits.
// RULE6: 2-bit pre-emphasis for all outputs: 00 none, 01 low, 10 medium, 11 high.
// RULE7: one output termination bit: 0 all output terminations off, 1 on.
// RULE8: one output current bit: 0 lower current, 1 doubled current, all channels.
// RULE9: parallel mode loads the registers straight from the dedicated strap pins.
// RULE10: strap path acts only after reset and until the first serial register access.
// RULE11: board ties each strap pin statically high or low, never toggling it; the board model changes the straps out of reset while tamper is set.
// RULE12: parallel mode holds both input termination registers at zero.
// RULE13: parallel mode copies the equalization strap into all sixteen equalizer bits.
// RULE14: parallel mode forces side path enable to 1, side source from source straps.
// RULE15: routing registers: enable bit 6, bits 5-2 read zero, source in bits 1:0.
// RULE16: transmitter register: pre-emphasis bits 3:2, termination bit 1, current bit 0.
// RULE17: fast path enable 0 puts channels in standby, 1 makes them active.
// RULE18: source select 00 routes A, 01 B, 10 C, 11 D to the output.
// RULE19: termination master bit 0 opens all inputs, 1 defers to per-channel bits.
// RULE20: controller pulses reset low after source straps change to adopt them.
// RULE21: straps latch after reset release; ignored after the first serial access.
`ifndef SWCFG_MAP_SVH
`define SWCFG_MAP_SVH

`define SWCFG_OFS_HS_ROUTE 8'h00
`define SWCFG_OFS_AUX_ROUTE 8'h01
`define SWCFG_OFS_RX_CONFIG 8'h10
`define SWCFG_OFS_RX_TERM_AB 8'h11
`define SWCFG_OFS_RX_TERM_CD 8'h12
`define SWCFG_OFS_IN_EQ_SEL_AB 8'h13
`define SWCFG_OFS_IN_EQ_SEL_CD 8'h14
`define SWCFG_OFS_TX_CONFIG 8'h20

`define SWCFG_RST_HS_ROUTE 8'h40
`define SWCFG_RST_AUX_ROUTE 8'h40
`define SWCFG_RST_RX_CONFIG 8'h01
`define SWCFG_RST_RX_TERM 8'h00
`define SWCFG_RST_IN_EQ_SEL 8'h00
`define SWCFG_RST_TX_CONFIG 8'h03

`define SWCFG_ROUTE_EN_BIT 6
`define SWCFG_ROUTE_MASK 8'h43
`define SWCFG_RXCFG_MASK 8'h01
`define SWCFG_TXCFG_MASK 8'h0F
`define SWCFG_OUT_PREEMPH_SEL_HI 3
`define SWCFG_OUT_PREEMPH_SEL_LO 2
`define SWCFG_TX_TERM_BIT 1
`define SWCFG_TX_CURR_BIT 0

// bit positions within the strap vector
`define SWCFG_STRAP_CURR 0
`define SWCFG_STRAP_TERM 1
`define SWCFG_STRAP_PE_LO 2
`define SWCFG_STRAP_PE_HI 3
`define SWCFG_STRAP_EQ 4
`define SWCFG_STRAP_SRC_LO 5
`define SWCFG_STRAP_SRC_HI 6
`define SWCFG_STRAP_EN 7

// cycles after reset release before synchronised straps are trusted
`define SWCFG_STRAP_SETTLE 2'h3

`endif

// File: verilog/swcfg_pkg.sv
// types of the switch configuration register bank
package swcfg_pkg;

    typedef struct packed {
        logic [7:0] strapS1;
        logic [7:0] strapS2;
        logic [7:0] strapS3;
        logic [1:0] settleCnt;
        logic parallelMode;
        logic [7:0] hsRoute;
        logic [7:0] auxRoute;
        logic [7:0] rxConfig;
        logic [7:0] termAb;
        logic [7:0] termCd;
        logic [7:0] eqAb;
        logic [7:0] eqCd;
        logic [7:0] txConfig;
        logic [7:0] rdData;
        logic [3:0] termA;
        logic [3:0] termB;
        logic [3:0] termC;
        logic [3:0] termD;
        logic [3:0] eqA;
        logic [3:0] eqB;
        logic [3:0] eqC;
        logic [3:0] eqD;
        logic [1:0] preemph;
        logic outTerm;
        logic outCurrent;
        logic fastEn;
        logic [1:0] fastSrc;
        logic sideEn;
        logic [1:0] sideSrc;
    } swcfg_state_t;

endpackage : swcfg_pkg

// File: verilog/swcfg_regs.sv
// configuration register bank of the 4:1 video link switch with strap loading
`timescale 1ns/1ps
`default_nettype none
`include "swcfg_map.svh"

module swcfg_regs import swcfg_pkg::*; (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // register access from the serial control interface
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData,
    // strap pins, static levels
    input wire logic strap_switch_enable,
    input wire logic [1:0] strap_source_sel,
    input wire logic strap_eq_level,
    input wire logic [1:0] strap_preemph_level,
    input wire logic strap_out_term,
    input wire logic strap_out_current,
    // per-channel input controls, index is channel number
    output logic [3:0] inTermA,
    output logic [3:0] inTermB,
    output logic [3:0] inTermC,
    output logic [3:0] inTermD,
    output logic [3:0] inEqA,
    output logic [3:0] inEqB,
    output logic [3:0] inEqC,
    output logic [3:0] inEqD,
    // output stage controls
    output logic [1:0] out_preemph_sel,
    output logic out_term_sel,
    output logic out_current_sel,
    // routing
    output logic fast_path_enable,
    output logic [1:0] fast_path_source,
    output logic side_path_enable,
    output logic [1:0] side_path_source,
    // status
    output logic parallelMode
);

    // C and D channels sit in reverse order within their nibble
    function automatic logic [3:0] swcfgReverse(input logic [3:0] v);
        swcfgReverse = {v[0], v[1], v[2], v[3]};
    endfunction : swcfgReverse

    logic rstSync1_q;
    logic rstSync2_q;
    logic [7:0] strapPins;
    logic strapLoad;
    logic access;
    swcfg_state_t st_q;
    swcfg_state_t st_d;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rstSync1_q <= 1'b0;
            rstSync2_q <= 1'b0;
        end else begin
            rstSync1_q <= 1'b1;
            rstSync2_q <= rstSync1_q;
        end
    end

    assign strapPins = {strap_switch_enable, strap_source_sel, strap_eq_level,
                        strap_preemph_level, strap_out_term, strap_out_current};
    assign access = regWrite | regRead;

    always_comb begin
        st_d = st_q;
        st_d.strapS1 = strapPins;
        st_d.strapS2 = st_q.strapS1;
        st_d.strapS3 = st_q.strapS2;
        if (st_q.settleCnt != `SWCFG_STRAP_SETTLE) begin
            st_d.settleCnt = st_q.settleCnt + 2'h1;
        end
        // straps taken once settled, second and third stage agreeing
        strapLoad = st_q.parallelMode && !access && (st_q.settleCnt == `SWCFG_STRAP_SETTLE)
                    && (st_q.strapS2 == st_q.strapS3); // RULE21
        if (strapLoad) begin // RULE9 RULE10
            st_d.hsRoute = {1'b0, st_q.strapS3[`SWCFG_STRAP_EN], 4'h0,
                            st_q.strapS3[`SWCFG_STRAP_SRC_HI:`SWCFG_STRAP_SRC_LO]};
            st_d.auxRoute = {1'b0, 1'b1, 4'h0,
                             st_q.strapS3[`SWCFG_STRAP_SRC_HI:`SWCFG_STRAP_SRC_LO]}; // RULE14
            st_d.rxConfig = `SWCFG_RST_RX_CONFIG;
            st_d.termAb = 8'h00; // RULE12
            st_d.termCd = 8'h00; // RULE12
            st_d.eqAb = {8{st_q.strapS3[`SWCFG_STRAP_EQ]}}; // RULE13
            st_d.eqCd = {8{st_q.strapS3[`SWCFG_STRAP_EQ]}}; // RULE13
            st_d.txConfig = {4'h0, st_q.strapS3[`SWCFG_STRAP_PE_HI:`SWCFG_STRAP_PE_LO],
                             st_q.strapS3[`SWCFG_STRAP_TERM], st_q.strapS3[`SWCFG_STRAP_CURR]};
        end
        if (access) begin
            st_d.parallelMode = 1'b0; // RULE10 RULE21
        end
        if (regWrite) begin
            unique case (regAddr)
                `SWCFG_OFS_HS_ROUTE: st_d.hsRoute = regWrData & `SWCFG_ROUTE_MASK; // RULE15
                `SWCFG_OFS_AUX_ROUTE: st_d.auxRoute = regWrData & `SWCFG_ROUTE_MASK; // RULE15
                `SWCFG_OFS_RX_CONFIG: st_d.rxConfig = regWrData & `SWCFG_RXCFG_MASK;
                `SWCFG_OFS_RX_TERM_AB: st_d.termAb = regWrData;
                `SWCFG_OFS_RX_TERM_CD: st_d.termCd = regWrData;
                `SWCFG_OFS_IN_EQ_SEL_AB: st_d.eqAb = regWrData;
                `SWCFG_OFS_IN_EQ_SEL_CD: st_d.eqCd = regWrData;
                `SWCFG_OFS_TX_CONFIG: st_d.txConfig = regWrData & `SWCFG_TXCFG_MASK; // RULE16
                default: st_d.hsRoute = st_q.hsRoute;
            endcase
        end
        if (regRead) begin
            unique case (regAddr)
                `SWCFG_OFS_HS_ROUTE: st_d.rdData = st_q.hsRoute;
                `SWCFG_OFS_AUX_ROUTE: st_d.rdData = st_q.auxRoute;
                `SWCFG_OFS_RX_CONFIG: st_d.rdData = st_q.rxConfig;
                `SWCFG_OFS_RX_TERM_AB: st_d.rdData = st_q.termAb;
                `SWCFG_OFS_RX_TERM_CD: st_d.rdData = st_q.termCd;
                `SWCFG_OFS_IN_EQ_SEL_AB: st_d.rdData = st_q.eqAb;
                `SWCFG_OFS_IN_EQ_SEL_CD: st_d.rdData = st_q.eqCd;
                `SWCFG_OFS_TX_CONFIG: st_d.rdData = st_q.txConfig;
                default: st_d.rdData = 8'h00;
            endcase
        end
        // per-channel decode; master bit gates every input termination
        st_d.termB = st_q.rxConfig[0] ? st_q.termAb[3:0] : 4'h0; // RULE1 RULE2 RULE19
        st_d.termA = st_q.rxConfig[0] ? st_q.termAb[7:4] : 4'h0; // RULE2 RULE19
        st_d.termC = st_q.rxConfig[0] ? swcfgReverse(st_q.termCd[3:0]) : 4'h0; // RULE3
        st_d.termD = st_q.rxConfig[0] ? swcfgReverse(st_q.termCd[7:4]) : 4'h0; // RULE3
        st_d.eqB = st_q.eqAb[3:0]; // RULE4 RULE5
        st_d.eqA = st_q.eqAb[7:4]; // RULE5
        st_d.eqC = swcfgReverse(st_q.eqCd[3:0]); // RULE5
        st_d.eqD = swcfgReverse(st_q.eqCd[7:4]); // RULE5
        st_d.preemph = st_q.txConfig[`SWCFG_OUT_PREEMPH_SEL_HI:`SWCFG_OUT_PREEMPH_SEL_LO]; // RULE6
        st_d.outTerm = st_q.txConfig[`SWCFG_TX_TERM_BIT]; // RULE7
        st_d.outCurrent = st_q.txConfig[`SWCFG_TX_CURR_BIT]; // RULE8
        st_d.fastEn = st_q.hsRoute[`SWCFG_ROUTE_EN_BIT]; // RULE17
        st_d.fastSrc = st_q.hsRoute[1:0]; // RULE18
        st_d.sideEn = st_q.auxRoute[`SWCFG_ROUTE_EN_BIT];
        st_d.sideSrc = st_q.auxRoute[1:0]; // RULE18
    end

    always_ff @(posedge core_clk or negedge rstSync2_q) begin
        if (!rstSync2_q) begin
            st_q <= '0;
            st_q.parallelMode <= 1'b1;
            st_q.hsRoute <= `SWCFG_RST_HS_ROUTE;
            st_q.auxRoute <= `SWCFG_RST_AUX_ROUTE;
            st_q.rxConfig <= `SWCFG_RST_RX_CONFIG;
            st_q.termAb <= `SWCFG_RST_RX_TERM;
            st_q.termCd <= `SWCFG_RST_RX_TERM;
            st_q.eqAb <= `SWCFG_RST_IN_EQ_SEL;
            st_q.eqCd <= `SWCFG_RST_IN_EQ_SEL;
            st_q.txConfig <= `SWCFG_RST_TX_CONFIG;
        end else begin
            st_q <= st_d;
        end
    end

    assign regRdData = st_q.rdData;
    assign inTermA = st_q.termA;
    assign inTermB = st_q.termB;
    assign inTermC = st_q.termC;
    assign inTermD = st_q.termD;
    assign inEqA = st_q.eqA;
    assign inEqB = st_q.eqB;
    assign inEqC = st_q.eqC;
    assign inEqD = st_q.eqD;
    assign out_preemph_sel = st_q.preemph;
    assign out_term_sel = st_q.outTerm;
    assign out_current_sel = st_q.outCurrent;
    assign fast_path_enable = st_q.fastEn;
    assign fast_path_source = st_q.fastSrc;
    assign side_path_enable = st_q.sideEn;
    assign side_path_source = st_q.sideSrc;
    assign parallelMode = st_q.parallelMode;

endmodule : swcfg_regs
`default_nettype wire

// File: verification/swcfg_regs_assertions.sv
// port-level checks of the switch config bank
`timescale 1ns/1ps
`default_nettype none
module swcfg_regs_assertions (
    input wire logic core_clk, reset_n, regWrite, regRead, parallelMode,
    input wire logic [7:0] regAddr, regWrData, regRdData,
    input wire logic [3:0] inTermA, inTermB, inTermC, inTermD, inEqA, inEqB, inEqC, inEqD,
    input wire logic [1:0] out_preemph_sel, fast_path_source, side_path_source,
    input wire logic out_term_sel, out_current_sel, fast_path_enable, side_path_enable
);
    logic [2:0] upCnt_q;
    logic [7:0] eqCd_q;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            upCnt_q <= 3'h0;
            eqCd_q <= 8'h00;
        end else begin
            upCnt_q <= (upCnt_q == 3'h7) ? upCnt_q : upCnt_q + 3'h1;
            eqCd_q <= (regWrite && regAddr == 8'h14) ? regWrData : eqCd_q;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    sequence eqCdWr;
        regWrite && regAddr == 8'h14 ##1 !(regWrite && regAddr == 8'h14);
    endsequence
    a_term_open_par: assert property (parallelMode |-> {inTermA, inTermB, inTermC, inTermD} == 16'h0000) else $error("input terminations closed in strap mode");
    a_eq_uniform_par: assert property (parallelMode |-> {inEqA, inEqB, inEqC, inEqD} inside {16'h0000, 16'hFFFF}) else $error("equalizers not uniform in strap mode");
    a_side_forced_on: assert property (parallelMode && upCnt_q == 3'h7 |-> side_path_enable && side_path_source == fast_path_source) else $error("side path not forced");
    a_access_ends_par: assert property ((regWrite || regRead) && upCnt_q == 3'h7 |=> !parallelMode) else $error("access left strap mode on");
    a_par_no_return: assert property (!parallelMode |=> !parallelMode) else $error("strap mode returned without reset");
    a_tx_read_back: assert property (regRead && regAddr == 8'h20 |=> regRdData == {4'h0, out_preemph_sel, out_term_sel, out_current_sel}) else $error("tx_config read mismatch");
    a_route_read_back: assert property (regRead && regAddr == 8'h00 |=> regRdData == {1'b0, fast_path_enable, 4'h0, fast_path_source}) else $error("hs_route_ctrl read mismatch");
    a_eq_cd_order: assert property (eqCdWr |=> inEqC == {eqCd_q[0], eqCd_q[1], eqCd_q[2], eqCd_q[3]} && inEqD == {eqCd_q[4], eqCd_q[5], eqCd_q[6], eqCd_q[7]}) else $error("eq cd bit order wrong");
endmodule : swcfg_regs_assertions
bind swcfg_regs swcfg_regs_assertions chk (.*);
`default_nettype wire

// File: verification/swcfg_strap_board.sv
// board model: static strap levels and a controller that pulses reset
`timescale 1ns/1ps
`default_nettype none
module swcfg_strap_board (
    input wire logic core_clk,
    input wire logic [7:0] cfg,
    input wire logic relatch,
    input wire logic tamper,
    output logic reset_n,
    output logic [7:0] straps
);
    int holdCnt;
    // straps move only under reset, unless a scenario tampers on purpose
    initial begin
        reset_n = 1'b0;
        straps = 8'h00;
        holdCnt = 0;
        forever begin
            @(posedge core_clk);
            if (relatch || holdCnt != 0) begin
                reset_n <= 1'b0;
                straps <= cfg;
                holdCnt <= relatch ? 20 : holdCnt - 1;
            end else begin
                reset_n <= 1'b1;
                straps <= tamper ? cfg : straps;
            end
        end
    end
endmodule : swcfg_strap_board
`default_nettype wire

// File: verification/swcfg_regs_test.sv
// self-checking bench of the switch config bank
`timescale 1ns/1ps
`default_nettype none
module swcfg_regs_test;
    logic core_clk, reset_n, regWrite, regRead, relatch, tamper, out_term_sel, out_current_sel;
    logic fast_path_enable, side_path_enable, parallelMode;
    logic [7:0] regAddr, regWrData, regRdData, cfg, straps, rdv;
    logic [3:0] inTermA, inTermB, inTermC, inTermD, inEqA, inEqB, inEqC, inEqD;
    logic [1:0] out_preemph_sel, fast_path_source, side_path_source;
    int err_total, comparisons, cycles;
    swcfg_strap_board board (.core_clk, .cfg, .relatch, .tamper, .reset_n, .straps);
    swcfg_regs DUT (.core_clk, .reset_n, .regWrite, .regRead, .regAddr, .regWrData, .regRdData,
        .strap_switch_enable(straps[7]), .strap_source_sel(straps[6:5]),
        .strap_eq_level(straps[4]), .strap_preemph_level(straps[3:2]),
        .strap_out_term(straps[1]), .strap_out_current(straps[0]), .inTermA, .inTermB, .inTermC,
        .inTermD, .inEqA, .inEqB, .inEqC, .inEqD, .out_preemph_sel, .out_term_sel,
        .out_current_sel, .fast_path_enable, .fast_path_source, .side_path_enable,
        .side_path_source, .parallelMode);
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // one access, then a spare cycle so decoded outputs have settled
    task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
        regAddr = a;
        regWrData = d;
        regWrite = wr;
        regRead = !wr;
        @(posedge core_clk);
        #1;
        regWrite = 1'b0;
        regRead = 1'b0;
        rdv = regRdData;
        @(posedge core_clk);
        #1;
    endtask : acc
    task automatic rst(input logic [7:0] c);
        cfg = c;
        relatch = 1'b1;
        @(posedge core_clk);
        #1;
        relatch = 1'b0;
        repeat (34) @(posedge core_clk);
        #1;
    endtask : rst
    task automatic outs(input logic [7:0] o, input logic [7:0] e, input logic [7:0] p);
        chk("route", o, {fast_path_enable, fast_path_source, side_path_enable, side_path_source,
            out_term_sel, out_current_sel});
        chk("eq ab", e, {inEqA, inEqB});
        chk("eq cd", e, {inEqC, inEqD});
        chk("term", 8'h00, {inTermA, inTermB} | {inTermC, inTermD});
        chk("mode", p, {5'h0, parallelMode, out_preemph_sel});
    endtask : outs
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            $display("ERROR timeout expected done seen running");
            stop_test();
        end
    end
    initial begin
        {regWrite, regRead, tamper, relatch} = 4'h0;
        regAddr = 8'h00;
        regWrData = 8'h00;
        rst(8'hD5);
        outs(8'hD9, 8'hFF, 8'h05);
        acc(1'b0, 8'h00, 8'h00);
        chk("hs_route_ctrl", 8'h42, rdv);
        chk("mode", 8'h00, {7'h0, parallelMode});
        acc(1'b0, 8'h14, 8'h00);
        chk("in_eq_sel_cd", 8'hFF, rdv);
        acc(1'b0, 8'h12, 8'h00);
        chk("rx_term_cd", 8'h00, rdv);
        acc(1'b0, 8'h10, 8'h00);
        chk("rx_config", 8'h01, rdv);
        cfg = 8'h2A;
        tamper = 1'b1;
        repeat (10) @(posedge core_clk);
        #1;
        tamper = 1'b0;
        outs(8'hD9, 8'hFF, 8'h01);
        rst(8'h2A);
        outs(8'h36, 8'h00, 8'h06);
        acc(1'b1, 8'h20, 8'hFF);
        acc(1'b0, 8'h20, 8'h00);
        chk("tx_config", 8'h0F, rdv);
        for (int p = 0; p < 4; p++) begin
            acc(1'b1, 8'h20, {4'hF, p[1:0], p[0], ~p[0]});
            chk("tx", {4'h0, p[1:0], p[0], ~p[0]}, {4'h0, out_preemph_sel, out_term_sel, out_current_sel});
        end
        acc(1'b1, 8'h10, 8'h01);
        acc(1'b1, 8'h11, 8'h1E);
        chk("term ab", 8'h1E, {inTermA, inTermB});
        acc(1'b1, 8'h12, 8'h1E);
        chk("term cd", 8'h78, {inTermC, inTermD});
        acc(1'b1, 8'h10, 8'h00);
        chk("term off", 8'h00, {inTermA, inTermB} | {inTermC, inTermD});
        acc(1'b1, 8'h13, 8'hA5);
        chk("eq ab", 8'hA5, {inEqA, inEqB});
        acc(1'b1, 8'h14, 8'h1E);
        chk("eq cd", 8'h78, {inEqC, inEqD});
        for (int s = 0; s < 4; s++) begin
            acc(1'b1, 8'h00, 8'hFC | s[7:0]);
            chk("source", {5'h0, 1'b1, s[1:0]}, {5'h0, fast_path_enable, fast_path_source});
            acc(1'b0, 8'h00, 8'h00);
            chk("hs_route_ctrl", 8'h40 | s[7:0], rdv);
        end
        acc(1'b1, 8'h00, 8'h03);
        chk("enable", 8'h00, {7'h0, fast_path_enable});
        acc(1'b1, 8'h01, 8'hBF);
        acc(1'b0, 8'h01, 8'h00);
        chk("aux_route_ctrl", 8'h03, rdv);
        acc(1'b0, 8'h05, 8'h00);
        chk("unmapped", 8'h00, rdv);
        stop_test();
    end
endmodule : swcfg_regs_test
`default_nettype wire
